// ---- test/fixed_priority_interrupt_controller_test.sv ----
// Self-checking bench for the interrupt unit and core pair
`timescale 1ns/100ps
`default_nettype none
module fixed_priority_interrupt_controller_test;
    import iu_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic [NUM_SRC-1:0] src_all;
    logic nmi_pin_n;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [31:0] rv;
    int err_total;
    int compares;
    iu_if bus_if ();
    // Two ends facing each other, checker beside them
    iu_unit iu_unit_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .BUS(bus_if.dev),
        .IRQ_SRC(src_all[NUM_SRC-1:1]), .NMI_PIN_N(nmi_pin_n));
    iu_core iu_core_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .BUS(bus_if.core),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
    iu_monitor iu_monitor_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
        .irq(bus_if.irq), .nmi(bus_if.nmi));
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Command port cycles
    task automatic cw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic cr(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Wait until the core has no bus op left
    task automatic idle();
        for (int n = 0; n < 50; n++)
        begin
            cr(CORE_STATUS, rv);
            if (rv[1:0] === 2'h0)
                return;
        end
        check("core idle", rv, 32'h0);
    endtask
    // Device register access through the core
    task automatic bus_wr(input logic [23:0] a, input logic [15:0] d);
        cw(CORE_BUS_ADDR, {8'h0, a});
        cw(CORE_BUS_WDATA, {16'h0, d});
        cw(CORE_COMMAND, 32'h1);
        idle();
    endtask
    task automatic rcheck(input string what, input logic [23:0] a, input logic [15:0] exp);
        cw(CORE_BUS_ADDR, {8'h0, a});
        cw(CORE_COMMAND, 32'h2);
        idle();
        cr(CORE_RDATA, rv);
        check(what, rv, {16'h0, exp});
    endtask
    task automatic pin_fall();
        @(posedge clk_sys);
        nmi_pin_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        nmi_pin_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic test_reset();
        rcheck("ena low", ADDR_ENA_LOW, ENA_RESET);
        rcheck("ena mid", ADDR_ENA_MID, ENA_RESET);
        rcheck("ena high", ADDR_ENA_HIGH, ENA_RESET);
        rcheck("trap", ADDR_TRAP_CTRL, 16'h0000);
        rcheck("nm stat", ADDR_NM_STATUS, 16'h0000);
        rcheck("vector", ADDR_VECTOR, 16'h0010);
        rcheck("unmapped", 24'hfffe06, 16'h0000);
        $display("test reset done");
    endtask
    task automatic test_priority();
        int idx[6] = '{1, 15, 16, 31, 32, 47};
        logic [23:0] st[3] = '{ADDR_STAT_LOW, ADDR_STAT_MID, ADDR_STAT_HIGH};
        foreach (idx[i])
        begin
            @(posedge clk_sys);
            src_all <= 48'h1 << idx[i];
            rcheck("vector", ADDR_VECTOR, 16'(idx[i] + 16));
            rcheck("status", st[idx[i] / 16], 16'h1 << (idx[i] % 16));
        end
        @(posedge clk_sys);
        src_all <= (48'h1 << 5) | (48'h1 << 40);
        rcheck("vector", ADDR_VECTOR, 16'h0038);
        bus_wr(ADDR_ENA_HIGH, 16'hfeff);
        rcheck("vector", ADDR_VECTOR, 16'h0015);
        rcheck("status", ADDR_STAT_HIGH, 16'h0100);
        bus_wr(ADDR_ENA_LOW, 16'hffdf);
        rcheck("vector", ADDR_VECTOR, 16'h0010);
        cr(CORE_STATUS, rv);
        check("irq off", {31'h0, rv[2]}, 32'h0);
        bus_wr(ADDR_ENA_LOW, ENA_RESET);
        bus_wr(ADDR_ENA_HIGH, ENA_RESET);
        rcheck("ena high", ADDR_ENA_HIGH, ENA_RESET);
        cr(CORE_STATUS, rv);
        check("irq on", {31'h0, rv[2]}, 32'h1);
        $display("test priority done");
    endtask
    task automatic test_ack();
        cw(CORE_CONTROL, 32'h1);
        repeat (10) @(posedge clk_sys);
        cr(CORE_LAST_VECTOR, rv);
        check("ack vector", rv, 32'h38);
        cr(CORE_CONTROL, rv);
        check("gie", rv, 32'h0);
        // Request dropped on the edge that restores global enable
        @(posedge clk_sys);
        src_all <= 48'h1 << 3;
        repeat (4) @(posedge clk_sys);
        cw(CORE_CONTROL, 32'h1);
        src_all <= '0;
        repeat (8) @(posedge clk_sys);
        cr(CORE_LAST_VECTOR, rv);
        check("drop vector", rv, {24'h0, VECTOR_BASE});
        cr(CORE_STATUS, rv);
        check("default hit", {31'h0, rv[3]}, 32'h1);
        cw(CORE_STATUS, 32'h0);
        cr(CORE_STATUS, rv);
        check("default clr", {31'h0, rv[3]}, 32'h0);
        $display("test ack done");
    endtask
    task automatic test_nmi();
        @(posedge clk_sys);
        nmi_pin_n <= 1'b0;
        rcheck("pin", ADDR_TRAP_CTRL, 16'h0002);
        @(posedge clk_sys);
        nmi_pin_n <= 1'b1;
        bus_wr(ADDR_TRAP_CTRL, 16'h0002);
        rcheck("pin wr", ADDR_TRAP_CTRL, 16'h0000);
        cr(CORE_NM_COUNT, rv);
        check("nm count", rv, 32'h0);
        bus_wr(ADDR_TRAP_CTRL, 16'h0001);
        rcheck("en", ADDR_TRAP_CTRL, 16'h0001);
        pin_fall();
        cr(CORE_NM_COUNT, rv);
        check("nm count", rv, 32'h1);
        rcheck("en clr", ADDR_TRAP_CTRL, 16'h0000);
        bus_wr(ADDR_TRAP_CTRL, 16'h0001);
        rcheck("en blk", ADDR_TRAP_CTRL, 16'h0000);
        rcheck("nm stat", ADDR_NM_STATUS, 16'h0001);
        rcheck("nm stat", ADDR_NM_STATUS, 16'h0000);
        bus_wr(ADDR_TRAP_CTRL, 16'h0001);
        rcheck("en", ADDR_TRAP_CTRL, 16'h0001);
        bus_wr(ADDR_TRAP_CTRL, 16'h0000);
        rcheck("en off", ADDR_TRAP_CTRL, 16'h0000);
        pin_fall();
        cr(CORE_NM_COUNT, rv);
        check("nm count", rv, 32'h1);
        $display("test nmi done");
    endtask
    task automatic test_lock();
        bus_wr(ADDR_TRAP_CTRL, 16'h0004);
        bus_wr(ADDR_TRAP_CTRL, 16'h0000);
        rcheck("lock", ADDR_TRAP_CTRL, 16'h0004);
        pin_fall();
        pin_fall();
        cr(CORE_NM_COUNT, rv);
        check("nm count", rv, 32'h3);
        rcheck("nm stat", ADDR_NM_STATUS, 16'h0001);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rcheck("lock rst", ADDR_TRAP_CTRL, 16'h0000);
        $display("test lock done");
    endtask
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        err_total = 0;
        compares = 0;
        reset_n = 1'b0;
        src_all = '0;
        nmi_pin_n = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        test_reset();
        test_priority();
        test_ack();
        test_nmi();
        test_lock();
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- test/iu_monitor.sv ----
// Checker on the bus between interrupt unit and core
`timescale 1ns/100ps
`default_nettype none
module iu_monitor
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Interface signals
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic irq,
    input wire logic nmi
);
    import iu_pkg::*;
    logic lock_seen;
    logic armed;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);
    // Remember enable writes to trap control
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            lock_seen <= 1'b0;
            armed <= 1'b0;
        end
        else if (wr && addr == ADDR_TRAP_CTRL)
        begin
            lock_seen <= lock_seen | wdata[TRAP_LOCK_BIT];
            armed <= armed | wdata[TRAP_LOCK_BIT] | wdata[TRAP_EN_BIT];
        end
    end
    // Register reads on the bus
    sequence vec_rd;
        rd && addr == ADDR_VECTOR;
    endsequence
    sequence trap_rd;
        rd && addr == ADDR_TRAP_CTRL;
    endsequence
    sequence stat_rd;
        rd && addr == ADDR_NM_STATUS;
    endsequence
    strobe_excl_a: assert property (!(wr && rd))
        else $error("read and write strobes together");
    idle_data_a: assert property (!rd |=> rdata == 16'h0)
        else $error("read data outside answer cycle");
    nmi_pulse_a: assert property (nmi |=> !nmi)
        else $error("nonmaskable request longer than one cycle");
    vec_range_a: assert property (vec_rd |=> rdata[15:6] == 10'h0 && rdata[5:4] != 2'h0)
        else $error("vector out of range");
    vec_live_a: assert property (vec_rd ##0 (irq && $past(irq)) |=> rdata[7:0] != 8'h10)
        else $error("vector empty while request pending");
    stat_bits_a: assert property (stat_rd |=> rdata[15:1] == 15'h0)
        else $error("status reserved bits set");
    trap_bits_a: assert property (trap_rd |=> rdata[15:3] == 13'h0)
        else $error("trap control reserved bits set");
    lock_hold_a: assert property (lock_seen ##0 trap_rd |=> rdata[TRAP_LOCK_BIT])
        else $error("enable lock lost");
    nmi_gate_a: assert property (nmi |-> armed)
        else $error("nonmaskable request while never enabled");
    nmi_ack_a: assert property (nmi |-> ##[1:8] vec_rd)
        else $error("no acknowledge after nonmaskable request");
    trap_wr_a: assert property (wr && addr == ADDR_TRAP_CTRL |-> wdata[15:3] == 13'h0)
        else $error("reserved trap control bits written nonzero");
endmodule
`default_nettype wire

// ---- verilog/iu_core.sv ----
// Processor core end: bus master, acknowledge cycles, command port
`timescale 1ns/100ps
`default_nettype none
module iu_core
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Interrupt unit side
    iu_if.core BUS,
    // Software command port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA
);
    import iu_pkg::*;

    iu_core_state_t state_reg;
    iu_core_state_t state_next;
    logic [23:0] bus_addr_reg;
    logic [15:0] bus_wdata_reg;
    logic gie_reg;
    logic op_pend_reg;
    logic op_is_wr_reg;
    logic [15:0] op_rdata_reg;
    logic [7:0] last_vector_reg;
    logic [7:0] nm_count_reg;
    logic nm_pend_reg;
    logic in_ack_reg;
    logic ack_data_reg;
    logic op_data_reg;
    logic default_hit_reg;
    logic [23:0] addr_reg;
    logic [15:0] wdata_reg;
    logic wr_reg;
    logic rd_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Command decode
    wire wr_cmd = WR && ADDR == CORE_COMMAND;
    wire start_op = wr_cmd && (WDATA[CMD_WRITE_BIT] || WDATA[CMD_READ_BIT]);
    wire take_nm = nm_pend_reg || BUS.nmi;
    wire take_mask = BUS.irq && gie_reg;
    wire idle = state_reg == IU_IDLE;
    wire do_ack = idle && (take_nm || take_mask);
    wire do_op = idle && !do_ack && op_pend_reg;
    // Reserved trap control bits forced to zero
    wire [15:0] op_wdata = bus_addr_reg == ADDR_TRAP_CTRL ?
        (bus_wdata_reg & TRAP_WRITE_MASK) : bus_wdata_reg;

    // Sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            IU_IDLE:
            begin
                if (do_ack)
                begin
                    state_next = IU_ACK_WAIT;
                end
                else if (do_op)
                begin
                    state_next = IU_OP_WAIT;
                end
            end
            IU_ACK_WAIT: state_next = IU_IDLE;
            IU_OP_WAIT: state_next = IU_IDLE;
            default: state_next = IU_IDLE;
        endcase
    end

    // Command port read mux
    always_comb
    begin
        rdata_next = 32'h0;
        case (ADDR)
            CORE_BUS_ADDR: rdata_next = {8'h00, bus_addr_reg};
            CORE_BUS_WDATA: rdata_next = {16'h0000, bus_wdata_reg};
            CORE_CONTROL: rdata_next = {31'h0, gie_reg};
            CORE_STATUS: rdata_next = {28'h0, default_hit_reg, BUS.irq, op_pend_reg, !idle};
            CORE_RDATA: rdata_next = {16'h0000, op_rdata_reg};
            CORE_LAST_VECTOR: rdata_next = {24'h0, last_vector_reg};
            CORE_NM_COUNT: rdata_next = {24'h0, nm_count_reg};
            default: rdata_next = 32'h0;
        endcase
    end

    // Software registers and interrupt bookkeeping
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            bus_addr_reg <= 24'h0;
            bus_wdata_reg <= 16'h0;
            gie_reg <= 1'b0;
            op_pend_reg <= 1'b0;
            op_is_wr_reg <= 1'b0;
            nm_pend_reg <= 1'b0;
            nm_count_reg <= 8'h0;
            last_vector_reg <= 8'h0;
            default_hit_reg <= 1'b0;
            op_rdata_reg <= 16'h0;
            in_ack_reg <= 1'b0;
            ack_data_reg <= 1'b0;
            op_data_reg <= 1'b0;
        end
        else
        begin
            if (WR && ADDR == CORE_BUS_ADDR)
            begin
                bus_addr_reg <= WDATA[23:0];
            end
            if (WR && ADDR == CORE_BUS_WDATA)
            begin
                bus_wdata_reg <= WDATA[15:0];
            end
            // Taking a maskable request clears global enable
            if (do_ack && !take_nm)
            begin
                gie_reg <= 1'b0;
            end
            else if (WR && ADDR == CORE_CONTROL)
            begin
                gie_reg <= WDATA[CTRL_GIE_BIT];
            end
            if (start_op)
            begin
                op_pend_reg <= 1'b1;
                op_is_wr_reg <= WDATA[CMD_WRITE_BIT];
            end
            else if (do_op)
            begin
                op_pend_reg <= 1'b0;
            end
            // Nonmaskable pulse held until its acknowledge cycle
            if (BUS.nmi && !do_ack)
            begin
                nm_pend_reg <= 1'b1;
            end
            else if (do_ack)
            begin
                nm_pend_reg <= 1'b0;
            end
            if (do_ack && take_nm)
            begin
                nm_count_reg <= nm_count_reg + 8'h01;
            end
            in_ack_reg <= do_ack && !take_nm;
            // Read data stands only in the cycle after the strobe
            ack_data_reg <= in_ack_reg;
            op_data_reg <= state_reg == IU_OP_WAIT && !op_is_wr_reg;
            // Software clear first so a same-cycle hit wins
            if (WR && ADDR == CORE_STATUS)
            begin
                default_hit_reg <= 1'b0;
            end
            if (ack_data_reg)
            begin
                last_vector_reg <= BUS.rdata[7:0];
                if (BUS.rdata[7:0] == VECTOR_BASE)
                begin
                    default_hit_reg <= 1'b1;
                end
            end
            if (op_data_reg)
            begin
                op_rdata_reg <= BUS.rdata;
            end
        end
    end

    // Bus strobes, one cycle each
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            state_reg <= IU_IDLE;
            addr_reg <= 24'h0;
            wdata_reg <= 16'h0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg <= do_ack ? ADDR_VECTOR : bus_addr_reg;
            wdata_reg <= op_wdata;
            wr_reg <= do_op && op_is_wr_reg;
            rd_reg <= do_ack || (do_op && !op_is_wr_reg);
            rdata_reg <= RD ? rdata_next : 32'h0;
        end
    end

    assign BUS.addr = addr_reg;
    assign BUS.wdata = wdata_reg;
    assign BUS.wr = wr_reg;
    assign BUS.rd = rd_reg;
    assign RDATA = rdata_reg;
endmodule
`default_nettype wire

// ---- verilog/iu_if.sv ----
// Bus and request lines between interrupt unit and processor core
`timescale 1ns/100ps
`default_nettype none
interface iu_if;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic irq;
    logic nmi;
    // Interrupt unit end
    modport dev (input addr, input wdata, input wr, input rd,
                 output rdata, output irq, output nmi);
    // Processor core end
    modport core (output addr, output wdata, output wr, output rd,
                  input rdata, input irq, input nmi);
endinterface
`default_nettype wire

// ---- verilog/iu_pkg.sv ----
// Shared constants for the interrupt unit and its processor-side partner
package iu_pkg;
    // Device bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NUM_SRC = 48;
    // Device register byte addresses
    localparam logic [23:0] ADDR_VECTOR = 24'hfffe00;
    localparam logic [23:0] ADDR_NM_STATUS = 24'hfffe02;
    localparam logic [23:0] ADDR_TRAP_CTRL = 24'hfffe04;
    localparam logic [23:0] ADDR_STAT_LOW = 24'hfffe0a;
    localparam logic [23:0] ADDR_STAT_MID = 24'hfffe0c;
    localparam logic [23:0] ADDR_ENA_LOW = 24'hfffe0e;
    localparam logic [23:0] ADDR_ENA_MID = 24'hfffe10;
    localparam logic [23:0] ADDR_STAT_HIGH = 24'hfffe20;
    localparam logic [23:0] ADDR_ENA_HIGH = 24'hfffe22;
    // Field positions
    localparam int TRAP_EN_BIT = 0;
    localparam int TRAP_PIN_BIT = 1;
    localparam int TRAP_LOCK_BIT = 2;
    localparam int NM_EXT_BIT = 0;
    localparam logic [15:0] TRAP_WRITE_MASK = 16'h0007;
    // Reset values and vector encoding
    localparam logic [15:0] ENA_RESET = 16'hffff;
    localparam logic [7:0] VECTOR_BASE = 8'h10;
    // Core command port register indices
    localparam logic [3:0] CORE_BUS_ADDR = 4'h0;
    localparam logic [3:0] CORE_BUS_WDATA = 4'h1;
    localparam logic [3:0] CORE_COMMAND = 4'h2;
    localparam logic [3:0] CORE_CONTROL = 4'h3;
    localparam logic [3:0] CORE_STATUS = 4'h4;
    localparam logic [3:0] CORE_RDATA = 4'h5;
    localparam logic [3:0] CORE_LAST_VECTOR = 4'h6;
    localparam logic [3:0] CORE_NM_COUNT = 4'h7;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CTRL_GIE_BIT = 0;
    // Core sequencer states
    typedef enum logic [1:0] {IU_IDLE, IU_ACK_WAIT, IU_OP_WAIT} iu_core_state_t;
endpackage

// ---- verilog/iu_unit.sv ----
// Interrupt unit: maskable priority encoder and nonmaskable trap logic
`timescale 1ns/100ps
`default_nettype none
module iu_unit
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Processor side
    iu_if.dev BUS,
    // Peripheral requests, index 1 upward, same clock
    input wire logic [iu_pkg::NUM_SRC-1:1] IRQ_SRC,
    // External nonmaskable pin, active low, asynchronous
    input wire logic NMI_PIN_N
);
    import iu_pkg::*;

    // Nonmaskable pin synchroniser and edge history
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    // Trap control and status
    logic trap_en_reg;
    logic trap_en_next;
    logic trap_lock_reg;
    logic trap_lock_next;
    logic ext_flag_reg;
    logic ext_flag_next;
    logic nmi_reg;
    // Per-source enables
    logic [15:0] ena_low_reg;
    logic [15:0] ena_mid_reg;
    logic [15:0] ena_high_reg;
    // Vector and request line
    logic [7:0] vector_reg;
    logic [7:0] vector_next;
    logic irq_reg;
    // Read data
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    // Register decode
    wire sel_vector = BUS.addr == ADDR_VECTOR;
    wire sel_nm_status = BUS.addr == ADDR_NM_STATUS;
    wire sel_trap = BUS.addr == ADDR_TRAP_CTRL;
    wire sel_stat_low = BUS.addr == ADDR_STAT_LOW;
    wire sel_stat_mid = BUS.addr == ADDR_STAT_MID;
    wire sel_stat_high = BUS.addr == ADDR_STAT_HIGH;
    wire sel_ena_low = BUS.addr == ADDR_ENA_LOW;
    wire sel_ena_mid = BUS.addr == ADDR_ENA_MID;
    wire sel_ena_high = BUS.addr == ADDR_ENA_HIGH;
    wire wr_trap = BUS.wr && sel_trap;
    wire rd_nm_status = BUS.rd && sel_nm_status;

    // Source vectors, index zero has no source
    wire [NUM_SRC-1:0] src_all = {IRQ_SRC, 1'b0};
    wire [NUM_SRC-1:0] ena_all = {ena_high_reg, ena_mid_reg, ena_low_reg[15:1], 1'b0};
    wire [NUM_SRC-1:0] pending = src_all & ena_all;

    // Nonmaskable edge and enable
    wire pin_asserted = ~pin_sync_reg;
    wire pin_fall = pin_prev_reg & ~pin_sync_reg;
    wire nm_enabled = trap_lock_reg | trap_en_reg;
    wire nm_event = pin_fall & nm_enabled;

    // Highest pending index wins; vector 10h when none
    always_comb
    begin
        vector_next = VECTOR_BASE;
        for (int i = 1; i < NUM_SRC; i++)
        begin
            if (pending[i])
            begin
                vector_next = VECTOR_BASE + 8'(i);
            end
        end
        vector_next[7:6] = 2'b00;
    end

    // Trap control and status next values
    always_comb
    begin
        trap_lock_next = trap_lock_reg;
        if (wr_trap && BUS.wdata[TRAP_LOCK_BIT])
        begin
            trap_lock_next = 1'b1;
        end
        trap_en_next = trap_en_reg;
        if (wr_trap)
        begin
            if (!BUS.wdata[TRAP_EN_BIT])
            begin
                trap_en_next = 1'b0;
            end
            else if (!ext_flag_reg)
            begin
                trap_en_next = 1'b1;
            end
        end
        if (nm_event)
        begin
            trap_en_next = 1'b0;
        end
        ext_flag_next = ext_flag_reg;
        if (rd_nm_status)
        begin
            ext_flag_next = 1'b0;
        end
        if (nm_event)
        begin
            ext_flag_next = 1'b1;
        end
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb
    begin
        rdata_next = 16'h0000;
        if (sel_vector)
        begin
            rdata_next = {8'h00, vector_reg};
        end
        else if (sel_nm_status)
        begin
            rdata_next[NM_EXT_BIT] = ext_flag_reg;
        end
        else if (sel_trap)
        begin
            rdata_next[TRAP_EN_BIT] = trap_en_reg;
            rdata_next[TRAP_PIN_BIT] = pin_asserted;
            rdata_next[TRAP_LOCK_BIT] = trap_lock_reg;
        end
        else if (sel_stat_low)
        begin
            rdata_next = src_all[15:0];
        end
        else if (sel_stat_mid)
        begin
            rdata_next = src_all[31:16];
        end
        else if (sel_stat_high)
        begin
            rdata_next = src_all[47:32];
        end
        else if (sel_ena_low)
        begin
            rdata_next = ena_low_reg;
        end
        else if (sel_ena_mid)
        begin
            rdata_next = ena_mid_reg;
        end
        else if (sel_ena_high)
        begin
            rdata_next = ena_high_reg;
        end
    end

    // Pin synchroniser, first stage read only by the second
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end
        else
        begin
            pin_meta_reg <= NMI_PIN_N;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Nonmaskable control state
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            trap_en_reg <= 1'b0;
            trap_lock_reg <= 1'b0;
            ext_flag_reg <= 1'b0;
            nmi_reg <= 1'b0;
        end
        else
        begin
            trap_en_reg <= trap_en_next;
            trap_lock_reg <= trap_lock_next;
            ext_flag_reg <= ext_flag_next;
            nmi_reg <= nm_event;
        end
    end

    // Per-source enable registers
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            ena_low_reg <= ENA_RESET;
            ena_mid_reg <= ENA_RESET;
            ena_high_reg <= ENA_RESET;
        end
        else if (BUS.wr)
        begin
            if (sel_ena_low)
            begin
                ena_low_reg <= BUS.wdata;
            end
            if (sel_ena_mid)
            begin
                ena_mid_reg <= BUS.wdata;
            end
            if (sel_ena_high)
            begin
                ena_high_reg <= BUS.wdata;
            end
        end
    end

    // Vector, request line and read data
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            vector_reg <= VECTOR_BASE;
            irq_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            vector_reg <= vector_next;
            irq_reg <= |pending;
            rdata_reg <= BUS.rd ? rdata_next : 16'h0000;
        end
    end

    // Outputs to the core
    assign BUS.rdata = rdata_reg;
    assign BUS.irq = irq_reg;
    assign BUS.nmi = nmi_reg;
endmodule
`default_nettype wire
